// *** src/ivt_pkg.sv ***
package ivt_pkg;
  // Register byte offsets
  localparam logic [7:0] IVT_CTRL_OFS = 8'h00;
  localparam logic [7:0] IVT_STAT_OFS = 8'h04;
  localparam logic [7:0] IVT_PRESET_OFS = 8'h08;
  localparam logic [7:0] IVT_EVT_OFS = 8'h0C;
  // Control register field positions
  localparam int IVT_TUNE_RUN_BIT = 6;
  localparam int IVT_SAMPLE_SEL_BIT = 7;
  localparam int IVT_DRV_LSB = 4;
  localparam int IVT_LOWV_BIT = 3;
  localparam int IVT_PRESET_EN_BIT = 15;
  // Status register field positions
  localparam int IVT_REG_STABLE_BIT = 0;
  localparam int IVT_TUNING_BIT = 1;
  localparam int IVT_CAP_LSB = 4;
  // Event register field positions
  localparam int IVT_EVT_TUNE_BIT = 0;
  localparam int IVT_EVT_SWFAIL_BIT = 1;
  // Reset values
  localparam logic [1:0] IVT_DRV_RESET = 2'h0;
  localparam logic [1:0] IVT_PRESET_RESET = 2'h0;
  // Drive kind encoding
  typedef enum logic [1:0] {
    IVT_DRV_B = 2'h0,
    IVT_DRV_A = 2'h1,
    IVT_DRV_C = 2'h2,
    IVT_DRV_D = 2'h3
  } ivt_drv_e;
  // Signals to the external tuning circuit
  typedef struct packed {
    logic start;
    logic retune;
    logic abort;
    logic reset_circuit;
  } ivt_tune_ctl_s;
  // Signals to the I/O regulator
  typedef struct packed {
    logic low_voltage_io_on;
    logic [1:0] drive_kind;
    logic drive_active;
  } ivt_io_ctl_s;
endpackage

// *** src/ivt_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ivt_sync #(
  parameter int WIDTH = 1
) (
  // Clocking
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // Two flops, first read only by second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** src/ivt_ctrl.sv ***
// Functional notes
// - Writing tuning run one starts tuning
// - Tuning run self-clears when tuning finishes
// - Writing zero aborts a running tuning
// - Sample select picks method, reports outcome
// - Drive kind: 0 B, 1 A, 2 C, 3 D
// - Drive kind ignored at 3.3V signalling
// - Without autoload, drive kind stays as written
// - With autoload, drive kind from preset value
// - Low-voltage bit rising starts 1.8V switch
// - Switch failure clears low-voltage bit
// - Low-voltage bit falling starts 3.3V switch
// - Regulator-settled status bit readable by software
// - After tuning, sample select shows result
// - Interrupts held off during tuning
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ivt_ctrl
  import ivt_pkg::*;
#(
  parameter int CAP_W = 3
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Tuning circuit
  input wire logic tune_done,
  input wire logic tune_ok,
  output ivt_pkg::ivt_tune_ctl_s tune_ctl,
  // Voltage regulator and card
  input wire logic switch_fail,
  input wire logic reg_stable,
  input wire logic [CAP_W-1:0] drv_caps,
  output ivt_pkg::ivt_io_ctl_s io_ctl,
  // Interrupt suppression and events
  output logic irq_hold,
  output logic tune_end_evt,
  output logic switch_fail_evt
);
  import ivt_pkg::*;

  typedef enum logic [2:0] {
    IVT_ST_IDLE = 3'h1,
    IVT_ST_RUN = 3'h2,
    IVT_ST_END = 3'h4
  } ivt_tune_e;

  ivt_tune_e state_reg, state_next;
  logic tune_run_reg;
  logic sample_sel_reg;
  logic [1:0] drv_reg;
  logic lowv_reg;
  logic preset_en_reg;
  logic [1:0] preset_hs_reg;
  logic [1:0] preset_ls_reg;
  logic ev_tune_reg;
  logic ev_swfail_reg;
  logic done_s, ok_s, fail_s, stable_s;
  logic wr_en, rd_en;
  logic wr_ctrl, wr_preset, wr_evt;
  logic wr_run_one, wr_run_zero;
  logic tune_finish;

  // Pin inputs through two flops
  ivt_sync #(.WIDTH(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .d({tune_done, tune_ok, switch_fail, reg_stable}),
    .q({done_s, ok_s, fail_s, stable_s})
  );

  // Address match for one register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Bus decode, zero wait state
  assign wr_en = psel && penable && pwrite && clk_en;
  assign rd_en = psel && !penable && !pwrite && clk_en;
  assign wr_ctrl = wr_en && hit(paddr, IVT_CTRL_OFS);
  assign wr_preset = wr_en && hit(paddr, IVT_PRESET_OFS);
  assign wr_evt = wr_en && hit(paddr, IVT_EVT_OFS);
  assign wr_run_one = wr_ctrl && pwdata[IVT_TUNE_RUN_BIT];
  assign wr_run_zero = wr_ctrl && !pwdata[IVT_TUNE_RUN_BIT];
  assign tune_finish = (state_reg == IVT_ST_RUN) && done_s;

  // Tuning sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IVT_ST_IDLE: begin
        if (wr_run_one) begin
          state_next = IVT_ST_RUN;
        end
      end
      IVT_ST_RUN: begin
        if (wr_run_zero) begin
          state_next = IVT_ST_IDLE;
        end else if (done_s) begin
          state_next = IVT_ST_END;
        end
      end
      IVT_ST_END: begin
        state_next = IVT_ST_IDLE;
      end
      default: begin
        state_next = IVT_ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= IVT_ST_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Tuning run bit: set by write, cleared on end or abort
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tune_run_reg <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == IVT_ST_IDLE && wr_run_one) begin
        tune_run_reg <= 1'b1;
      end else if (state_reg == IVT_ST_RUN && wr_run_zero) begin
        tune_run_reg <= 1'b0;
      end else if (tune_finish) begin
        tune_run_reg <= 1'b0;
      end
    end
  end

  // Sample select: method at start, outcome after end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_sel_reg <= 1'b0;
    end else if (clk_en) begin
      if (tune_finish && !wr_run_zero) begin
        sample_sel_reg <= ok_s;
      end else if (state_reg == IVT_ST_RUN && wr_run_zero) begin
        sample_sel_reg <= 1'b0;
      end else if (wr_ctrl && state_reg == IVT_ST_IDLE) begin
        sample_sel_reg <= pwdata[IVT_SAMPLE_SEL_BIT];
      end
    end
  end

  // Tuning circuit controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tune_ctl <= '0;
    end else if (clk_en) begin
      tune_ctl.start <= (state_reg == IVT_ST_IDLE) && wr_run_one;
      tune_ctl.retune <= pwdata[IVT_SAMPLE_SEL_BIT];
      tune_ctl.abort <= (state_reg == IVT_ST_RUN) && wr_run_zero;
      tune_ctl.reset_circuit <= (state_reg == IVT_ST_IDLE) && wr_ctrl
        && !pwdata[IVT_SAMPLE_SEL_BIT];
    end
  end

  // Preset autoload enable and preset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_en_reg <= 1'b0;
      preset_hs_reg <= IVT_PRESET_RESET;
      preset_ls_reg <= IVT_PRESET_RESET;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        preset_en_reg <= pwdata[IVT_PRESET_EN_BIT];
      end
      if (wr_preset) begin
        preset_hs_reg <= pwdata[1:0];
        preset_ls_reg <= pwdata[17:16];
      end
    end
  end

  // Drive kind field: software or preset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_reg <= IVT_DRV_RESET;
    end else if (clk_en) begin
      if (preset_en_reg) begin
        drv_reg <= lowv_reg ? preset_hs_reg : preset_ls_reg;
      end else if (wr_ctrl) begin
        drv_reg <= pwdata[IVT_DRV_LSB +: 2];
      end
    end
  end

  // Low-voltage bit, failure clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowv_reg <= 1'b0;
    end else if (clk_en) begin
      if (fail_s && lowv_reg) begin
        lowv_reg <= 1'b0;
      end else if (wr_ctrl) begin
        lowv_reg <= pwdata[IVT_LOWV_BIT];
      end
    end
  end

  // Regulator outputs; drive kind only at 1.8V
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_ctl <= '0;
    end else if (clk_en) begin
      io_ctl.low_voltage_io_on <= lowv_reg;
      io_ctl.drive_kind <= lowv_reg ? drv_reg : IVT_DRV_B;
      io_ctl.drive_active <= lowv_reg;
    end
  end

  // Sticky events, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_tune_reg <= 1'b0;
      ev_swfail_reg <= 1'b0;
    end else if (clk_en) begin
      if (tune_finish) begin
        ev_tune_reg <= 1'b1;
      end else if (wr_evt && pwdata[IVT_EVT_TUNE_BIT]) begin
        ev_tune_reg <= 1'b0;
      end
      if (fail_s && lowv_reg) begin
        ev_swfail_reg <= 1'b1;
      end else if (wr_evt && pwdata[IVT_EVT_SWFAIL_BIT]) begin
        ev_swfail_reg <= 1'b0;
      end
    end
  end

  // Event pulses and interrupt hold-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tune_end_evt <= 1'b0;
      switch_fail_evt <= 1'b0;
      irq_hold <= 1'b0;
    end else if (clk_en) begin
      tune_end_evt <= tune_finish;
      switch_fail_evt <= fail_s && lowv_reg;
      irq_hold <= (state_next == IVT_ST_RUN);
    end
  end

  // Read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(hit(paddr, IVT_CTRL_OFS)
        || hit(paddr, IVT_STAT_OFS) || hit(paddr, IVT_PRESET_OFS)
        || hit(paddr, IVT_EVT_OFS));
      if (rd_en) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          IVT_CTRL_OFS: begin
            prdata[IVT_SAMPLE_SEL_BIT] <= sample_sel_reg;
            prdata[IVT_TUNE_RUN_BIT] <= tune_run_reg;
            prdata[IVT_DRV_LSB +: 2] <= drv_reg;
            prdata[IVT_LOWV_BIT] <= lowv_reg;
            prdata[IVT_PRESET_EN_BIT] <= preset_en_reg;
          end
          IVT_STAT_OFS: begin
            prdata[IVT_REG_STABLE_BIT] <= stable_s;
            prdata[IVT_TUNING_BIT] <= (state_reg == IVT_ST_RUN);
            prdata[IVT_CAP_LSB +: CAP_W] <= drv_caps;
          end
          IVT_PRESET_OFS: begin
            prdata[1:0] <= preset_hs_reg;
            prdata[17:16] <= preset_ls_reg;
          end
          IVT_EVT_OFS: begin
            prdata[IVT_EVT_TUNE_BIT] <= ev_tune_reg;
            prdata[IVT_EVT_SWFAIL_BIT] <= ev_swfail_reg;
          end
          default: begin
            prdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Run bit falls in the cycle after finish
  sequence run_seq;
    tune_run_reg && state_reg == IVT_ST_RUN;
  endsequence
  run_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_seq and tune_finish && clk_en |=> !tune_run_reg)
    else $error("tuning run bit not cleared");
  start_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == IVT_ST_IDLE && wr_run_one |=> tune_run_reg && tune_ctl.start)
    else $error("tuning did not start");
  abort_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == IVT_ST_RUN && wr_run_zero |=> !tune_run_reg && tune_ctl.abort)
    else $error("abort not honoured");
  result_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && tune_finish && !wr_run_zero |=> sample_sel_reg == $past(ok_s))
    else $error("tuning result not reported");
  drive_hv_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !lowv_reg |=> io_ctl.drive_kind == IVT_DRV_B)
    else $error("drive kind active at 3.3V");
  swfail_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && fail_s && lowv_reg |=> !lowv_reg)
    else $error("low-voltage bit kept after failure");
  manual_drv_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !preset_en_reg && !wr_ctrl |=> drv_reg == $past(drv_reg))
    else $error("drive kind changed without write");
  event_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && tune_finish |=> ev_tune_reg && tune_end_evt)
    else $error("tuning end event missing");
  hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && state_reg == IVT_ST_RUN && !wr_run_zero && !done_s |=> irq_hold)
    else $error("interrupts not held during tuning");
  lowv_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> io_ctl.low_voltage_io_on == $past(lowv_reg))
    else $error("signalling level request not forwarded");
  preset_drv_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && preset_en_reg && lowv_reg |=> drv_reg == $past(preset_hs_reg))
    else $error("drive kind not loaded from preset");
endmodule
`default_nettype wire

// *** tb/ivt_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ivt_card_model
  import ivt_pkg::*;
(
  // Clocking
  input wire logic pclk,
  input wire logic presetn,
  // Scenario knobs
  input wire logic ok_cfg,
  input wire logic fail_cfg,
  input wire logic slow_cfg,
  // Controller side
  input wire ivt_pkg::ivt_tune_ctl_s tune_ctl,
  input wire ivt_pkg::ivt_io_ctl_s io_ctl,
  output logic tune_done,
  output logic tune_ok,
  output logic switch_fail,
  output logic reg_stable
);
  logic [7:0] cnt_reg;
  logic busy_reg;
  logic [3:0] settle_reg;
  logic lowv_reg;
  // Tuning counter counts down while busy until it reaches zero or the run is aborted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (tune_ctl.start) begin
      busy_reg <= 1'b1;
      cnt_reg <= slow_cfg ? 8'hC8 : 8'h14;
    end else if (tune_ctl.abort || cnt_reg == 8'h00) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  // Done held four cycles so the synchroniser sees it
  assign tune_done = busy_reg && (cnt_reg < 8'h04);
  assign tune_ok = ok_cfg;
  // Regulator drops its settled flag for a while after each level change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowv_reg <= 1'b0;
      settle_reg <= 4'h0;
    end else begin
      lowv_reg <= io_ctl.low_voltage_io_on;
      if (lowv_reg != io_ctl.low_voltage_io_on) settle_reg <= 4'h8;
      else if (settle_reg != 4'h0) settle_reg <= settle_reg - 4'h1;
    end
  end
  assign reg_stable = (settle_reg == 4'h0);
  assign switch_fail = fail_cfg && io_ctl.low_voltage_io_on;
endmodule
`default_nettype wire

// *** tb/io_voltage_tuning_control_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module io_voltage_tuning_control_tb_top;
  import ivt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic tune_done, tune_ok, switch_fail, reg_stable, irq_hold, tune_end_evt, switch_fail_evt;
  logic ok_cfg, fail_cfg, slow_cfg;
  logic clk_en;
  logic [2:0] drv_caps;
  ivt_tune_ctl_s tune_ctl;
  ivt_io_ctl_s io_ctl;
  int err_count, tests_run, n_start, n_abort, n_tend, n_sfail, n_rst;
  // Design and far side
  ivt_ctrl #(.CAP_W(3)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tune_done(tune_done), .tune_ok(tune_ok),
    .tune_ctl(tune_ctl), .switch_fail(switch_fail), .reg_stable(reg_stable),
    .drv_caps(drv_caps), .io_ctl(io_ctl), .irq_hold(irq_hold), .tune_end_evt(tune_end_evt),
    .switch_fail_evt(switch_fail_evt));
  ivt_card_model far (.pclk(pclk), .presetn(presetn), .ok_cfg(ok_cfg), .fail_cfg(fail_cfg),
    .slow_cfg(slow_cfg), .tune_ctl(tune_ctl), .io_ctl(io_ctl), .tune_done(tune_done),
    .tune_ok(tune_ok), .switch_fail(switch_fail), .reg_stable(reg_stable));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Pulse counters
  always @(posedge pclk) begin
    if (tune_ctl.start === 1'b1) n_start++;
    if (tune_ctl.abort === 1'b1) n_abort++;
    if (tune_ctl.reset_circuit === 1'b1) n_rst++;
    if (tune_end_evt === 1'b1) n_tend++;
    if (switch_fail_evt === 1'b1) n_sfail++;
  end
  task automatic complete_run();
    $display("errors %0d, comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic t_reset();
    apb(1'b0, IVT_CTRL_OFS, 32'h0);
    `CHK(r[7:3], 5'h00)
    `CHK(io_ctl, 4'h0)
    apb(1'b0, IVT_STAT_OFS, 32'h0);
    `CHK(r[6:4], drv_caps)
  endtask
  task automatic t_drive();
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, IVT_CTRL_OFS, 32'h8 | (k << 4));
      settle(2);
      `CHK(io_ctl.drive_kind, 2'(k))
      `CHK(io_ctl.drive_active, 1'b1)
      apb(1'b0, IVT_CTRL_OFS, 32'h0);
      `CHK(r[5:4], 2'(k))
    end
    apb(1'b1, IVT_CTRL_OFS, 32'h30);
    settle(2);
    `CHK(io_ctl.drive_kind, IVT_DRV_B)
    `CHK(io_ctl.drive_active, 1'b0)
    `CHK(io_ctl.low_voltage_io_on, 1'b0)
  endtask
  task automatic t_preset();
    apb(1'b1, IVT_PRESET_OFS, 32'h0001_0002);
    apb(1'b1, IVT_CTRL_OFS, 32'h8018);
    settle(3);
    `CHK(io_ctl.drive_kind, IVT_DRV_C)
    apb(1'b1, IVT_CTRL_OFS, 32'h8000);
    settle(2);
    apb(1'b0, IVT_CTRL_OFS, 32'h0);
    `CHK(r[5:4], IVT_DRV_A)
    apb(1'b1, IVT_CTRL_OFS, 32'h0);
  endtask
  task automatic t_tune(input logic ok, input logic sel, input logic abort);
    int i;
    ok_cfg <= ok;
    slow_cfg <= abort;
    apb(1'b1, IVT_EVT_OFS, 32'h3);
    n_start = 0;
    n_abort = 0;
    n_tend = 0;
    n_rst = 0;
    apb(1'b1, IVT_CTRL_OFS, {24'h0, sel, 7'h40});
    settle(2);
    `CHK(n_start, 1)
    `CHK(tune_ctl.retune, sel)
    `CHK(n_rst, !sel)
    `CHK(irq_hold, 1'b1)
    apb(1'b0, IVT_STAT_OFS, 32'h0);
    `CHK(r[1], 1'b1)
    if (abort) begin
      apb(1'b1, IVT_CTRL_OFS, 32'h0);
      settle(4);
      `CHK(n_abort, 1)
    end
    i = 0;
    do begin
      apb(1'b0, IVT_CTRL_OFS, 32'h0);
      i++;
    end while (r[6] !== 1'b0 && i < 60);
    `CHK(r[6], 1'b0)
    `CHK(r[7], ok && !abort)
    `CHK(irq_hold, 1'b0)
    apb(1'b0, IVT_EVT_OFS, 32'h0);
    `CHK(r[0], !abort)
    `CHK(n_tend, !abort)
  endtask
  task automatic t_switch();
    fail_cfg <= 1'b1;
    n_sfail = 0;
    apb(1'b1, IVT_CTRL_OFS, 32'h8);
    settle(8);
    apb(1'b0, IVT_CTRL_OFS, 32'h0);
    `CHK(r[3], 1'b0)
    `CHK(n_sfail, 1)
    apb(1'b0, IVT_EVT_OFS, 32'h0);
    `CHK(r[1], 1'b1)
    fail_cfg <= 1'b0;
    apb(1'b1, IVT_CTRL_OFS, 32'h8);
    settle(2);
    `CHK(io_ctl.low_voltage_io_on, 1'b1)
    settle(4);
    apb(1'b0, IVT_STAT_OFS, 32'h0);
    `CHK(r[0], 1'b0)
    settle(20);
    apb(1'b0, IVT_STAT_OFS, 32'h0);
    `CHK(r[0], 1'b1)
    apb(1'b1, IVT_CTRL_OFS, 32'h0);
    settle(2);
    `CHK(io_ctl.low_voltage_io_on, 1'b0)
    apb(1'b0, 8'h10, 32'h0);
    `CHK(perr, 1'b1)
  endtask
  // Clock enable low freezes every register
  task automatic t_freeze();
    apb(1'b1, IVT_CTRL_OFS, 32'h8);
    clk_en <= 1'b0;
    settle(3);
    `CHK(io_ctl.low_voltage_io_on, 1'b0)
    clk_en <= 1'b1;
    settle(2);
    `CHK(io_ctl.low_voltage_io_on, 1'b1)
    apb(1'b1, IVT_CTRL_OFS, 32'h0);
    settle(2);
  endtask
  // Watchdog
  initial begin
    #2000000;
    err_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ok_cfg, fail_cfg, slow_cfg} = 3'b100;
    clk_en = 1'b1;
    drv_caps = 3'h7;
    presetn = 1'b0;
    settle(16);
    presetn <= 1'b0 | 1'b1;
    t_reset();
    t_drive();
    t_preset();
    t_tune(1'b1, 1'b0, 1'b0);
    t_tune(1'b1, 1'b1, 1'b0);
    t_tune(1'b0, 1'b0, 1'b0);
    t_tune(1'b1, 1'b0, 1'b1);
    t_freeze();
    t_switch();
    complete_run();
  end
endmodule
`default_nettype wire
